// ### pkg/dyn_term_pkg.sv
// constants, types and register map of the dynamic termination controller
// Summary of operation
// - dynamic switching enabled when mode_register_two bit A9 or A10 is one
// - nominal termination value comes from mode_register_one bits A9, A6, A2
// - write termination value comes from mode_register_two bits A10, A9
// - without writes, nominal value applies; on/off follows ODT after latencies
// - every write variant triggers the strength switch when enabled
// - write value selected nom_to_write_latency cycles after the write
// - return to nominal after bl8 or bc4 latency, mode or on-the-fly
// - on and off latencies both equal write_latency minus two
// - bc4 reversion at four plus termination_off_latency after the write
// - bl8 reversion at six plus termination_off_latency after the write
// - strength changes during writes need no mode register set
// - termination off when ODT low; on when high unless all selects zero
// - write_latency is CAS write latency plus additive latency
// - in self-refresh ODT is ignored and termination kept off
package dyn_term_pkg;
  localparam logic [7:0] addr_mode_one = 8'h00;
  localparam logic [7:0] addr_mode_two = 8'h04;
  localparam logic [7:0] addr_control = 8'h08;
  localparam logic [7:0] addr_status = 8'h0c;
  localparam logic [7:0] addr_latency = 8'h10;
  localparam int mr_width = 16;
  localparam int pos_a2 = 2;
  localparam int pos_a6 = 6;
  localparam int pos_a9 = 9;
  localparam int pos_a10 = 10;
  localparam int pos_cwl = 3;
  localparam int pos_al = 3;
  localparam logic [mr_width-1:0] mode_one_reset = 16'h0000;
  localparam logic [mr_width-1:0] mode_two_reset = 16'h0000;
  localparam logic [4:0] cwl_base = 5'h05;
  localparam logic [4:0] latency_offset = 5'h02;
  localparam logic [4:0] bc4_extra = 5'h04;
  localparam logic [4:0] bl8_extra = 5'h06;
  localparam int pipe_depth = 32;
  localparam logic [31:0] bus_error_data = 32'h00000000;

  typedef struct packed {
    logic odt;
    logic write_cmd;
    logic chop4;
  } pin_sample_type;

  typedef struct packed {
    logic on;
    logic write_strength;
    logic [2:0] nominal;
    logic [1:0] write_value;
  } term_state_type;
endpackage

// ### rtl/delay_line.sv
// fixed-length shift line with a variable tap
`timescale 1ns/1ns
module delay_line #(
  parameter int depth = 32,
  parameter int width = 1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [width-1:0] data_i,
  input wire logic [4:0] tap_i,
  output logic [width-1:0] data_o
);
  logic [width-1:0] stage [depth];
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < depth; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= data_i;
      for (int i = 1; i < depth; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end
  // tap 1 means one edge after data_i, tap 0 passes data_i straight through
  always_comb begin
    data_o = (tap_i == 5'h00) ? data_i : stage[tap_i - 5'h01];
  end
endmodule // delay_line

// ### rtl/dyn_term_ctrl.sv
// dynamic termination controller with apb register access
`timescale 1ns/1ns
module dyn_term_ctrl (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic odt_pin_i,
  input wire logic write_cmd_i,
  input wire logic chop4_i,
  input wire logic self_refresh_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output dyn_term_pkg::term_state_type term_o
);
  import dyn_term_pkg::*;

  logic [mr_width-1:0] mode_one;
  logic [mr_width-1:0] mode_two;
  logic bc4_fixed;
  pin_sample_type sync1;
  pin_sample_type sync2;
  logic sr1;
  logic sr2;
  logic [4:0] write_latency;
  logic [4:0] term_latency;
  logic [4:0] cwn_latency;
  logic [2:0] nominal_value;
  logic [1:0] write_value;
  logic dynamic_en;
  logic any_select;
  logic odt_late;
  logic write_in;
  logic write_late_cnw;
  logic [4:0] win_cnt;
  logic [4:0] next_win_cnt;
  logic [4:0] start_cnt;
  logic access;

  // pins from the controller pass two flops
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sr1 <= 1'b0;
      sr2 <= 1'b0;
    end else begin
      sync1 <= '{odt: odt_pin_i, write_cmd: write_cmd_i, chop4: chop4_i};
      sync2 <= sync1;
      sr1 <= self_refresh_i;
      sr2 <= sr1;
    end
  end

  // apb slave, zero wait states
  assign access = psel_i && penable_i;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_one <= mode_one_reset;
      mode_two <= mode_two_reset;
      bc4_fixed <= 1'b0;
    end else if (access && pwrite_i) begin
      unique case (paddr_i)
        addr_mode_one: mode_one <= pwdata_i[mr_width-1:0];
        addr_mode_two: mode_two <= pwdata_i[mr_width-1:0];
        addr_control: bc4_fixed <= pwdata_i[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= bus_error_data;
      if (psel_i && !penable_i) begin
        unique case (paddr_i)
          addr_mode_one: prdata_o <= {16'h0000, mode_one};
          addr_mode_two: prdata_o <= {16'h0000, mode_two};
          addr_control: prdata_o <= {31'h00000000, bc4_fixed};
          addr_status: prdata_o <= {24'h000000, term_o, 1'b0};
          addr_latency: prdata_o <= {27'h0000000, write_latency};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  assign nominal_value = {mode_one[pos_a9], mode_one[pos_a6], mode_one[pos_a2]};
  assign write_value = {mode_two[pos_a10], mode_two[pos_a9]};
  assign dynamic_en = mode_two[pos_a10] | mode_two[pos_a9];
  assign any_select = (nominal_value != 3'h0) || dynamic_en;
  // cwl plus additive latency, minus two
  assign write_latency = cwl_base + {2'h0, mode_two[pos_cwl+2:pos_cwl]}
    + {3'h0, mode_one[pos_al+1:pos_al]};
  assign term_latency = write_latency - latency_offset;
  // any write variant starts the window
  assign write_in = sync2.write_cmd && dynamic_en && !sr2;

  delay_line #(.depth(pipe_depth), .width(1)) odt_delay (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .data_i(sync2.odt),
    .tap_i(term_latency),
    .data_o(odt_late)
  );

  delay_line #(.depth(pipe_depth), .width(1)) cnw_delay (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .data_i(write_in),
    .tap_i(term_latency),
    .data_o(write_late_cnw)
  );

  // window length from write strength start to reversion
  assign cwn_latency = (sync2.chop4 || bc4_fixed) ? bc4_extra : bl8_extra;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      start_cnt <= '0;
    end else if (write_in) begin
      start_cnt <= cwn_latency;
    end
  end

  always_comb begin
    next_win_cnt = win_cnt;
    if (write_late_cnw) begin
      next_win_cnt = start_cnt;
    end else if (win_cnt != 5'h00) begin
      next_win_cnt = win_cnt - 5'h01;
    end
  end

  // strength changes without any mode set
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      win_cnt <= '0;
    end else begin
      win_cnt <= next_win_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      term_o <= '0;
    end else begin
      term_o.on <= odt_late && any_select && !sr2;
      term_o.write_strength <= (next_win_cnt != 5'h00);
      term_o.nominal <= nominal_value;
      term_o.write_value <= write_value;
    end
  end

  chk_self_refresh_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sr2 |=> !term_o.on) else $error("termination on in self refresh");
  chk_off_when_unset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !any_select |=> !term_o.on) else $error("termination on with no select");
  chk_enable_bits: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (write_in |-> (mode_two[pos_a9] || mode_two[pos_a10])))
    else $error("write window without enable");
  chk_latency_sum: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    term_latency == write_latency - 5'h02) else $error("latency mismatch");
  chk_nominal_bits: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 term_o.nominal == $past({mode_one[9], mode_one[6], mode_one[2]}))
    else $error("nominal select wrong");
  chk_write_bits: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 term_o.write_value == $past({mode_two[10], mode_two[9]}))
    else $error("write select wrong");
  chk_write_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    write_late_cnw |=> term_o.write_strength) else $error("write strength late");
  chk_bc4_revert: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (write_late_cnw && start_cnt == 5'h04 && !write_in) ##1 !write_late_cnw [*4]
    |=> !term_o.write_strength) else $error("bc4 reversion wrong");
  chk_bl8_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (write_late_cnw && start_cnt == 5'h06) |=> term_o.write_strength [*6])
    else $error("bl8 window short");
  chk_odt_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (odt_late && any_select && !sr2) |=> term_o.on) else $error("odt not followed");
  cov_write_bl8: cover property (@(posedge clk_i) write_in && !sync2.chop4 && !bc4_fixed);
  cov_write_bc4: cover property (@(posedge clk_i) write_in && sync2.chop4);
  cov_term_on: cover property (@(posedge clk_i) term_o.on && term_o.write_strength);
endmodule // dyn_term_ctrl

// ### verification/ctrl_model.sv
// memory controller model driving odt and write commands
`timescale 1ns/1ns
module ctrl_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic wr_i,
  input wire logic chop_i,
  output logic odt_o = 1'b0,
  output logic write_o = 1'b0,
  output logic chop4_o = 1'b0
);
  logic [3:0] hold = 4'h0;
  always @(posedge clk_i) begin
    write_o <= 1'b0;
    chop4_o <= 1'b0;
    if (go_i && hold == 4'h0) begin
      odt_o <= 1'b1;
      write_o <= wr_i;
      chop4_o <= wr_i & chop_i;
      hold <= (wr_i && !chop_i) ? 4'h6 : 4'h4;
    end else if (hold > 4'h1) begin
      hold <= hold - 4'h1;
    end else if (hold == 4'h1) begin
      odt_o <= 1'b0;
      hold <= 4'h0;
    end
  end
endmodule // ctrl_model

// ### verification/testbench.sv
// self-checking bench for the dynamic termination controller
`timescale 1ns/1ns
module testbench;
  import dyn_term_pkg::*;
  logic clk_i, sys_rst_i = 1'b1, sr = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic go = 1'b0, wr = 1'b0, c4 = 1'b0, pready, perr, perr_q, odt, wcmd, ch4;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic [2:0] nom;
  logic [1:0] wv;
  term_state_type term;
  int n_errors = 0, check_count = 0, on_n, on_len, ws_n, ws_len;
  ctrl_model i_ctrl_model (.clk_i(clk_i), .go_i(go), .wr_i(wr), .chop_i(c4),
    .odt_o(odt), .write_o(wcmd), .chop4_o(ch4));
  dyn_term_ctrl i_dyn_term_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .odt_pin_i(odt),
    .write_cmd_i(wcmd), .chop4_i(ch4), .self_refresh_i(sr), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .term_o(term));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h00000001);
    q = prdata;
    perr_q = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic run(input logic w, input logic c);
    on_n = 0;
    on_len = 0;
    ws_n = 0;
    ws_len = 0;
    go <= 1'b1;
    wr <= w;
    c4 <= c;
    @(posedge clk_i);
    go <= 1'b0;
    for (int i = 1; i < 30; i++) begin
      @(negedge clk_i);
      if (term.on === 1'b1 && on_n == 0) begin
        on_n = i;
        nom = term.nominal;
      end
      if (term.write_strength === 1'b1 && ws_n == 0) begin
        ws_n = i;
        wv = term.write_value;
      end
      on_len += (term.on === 1'b1);
      ws_len += (term.write_strength === 1'b1);
    end
    @(posedge clk_i);
  endtask
  task automatic t_regs;
    apb(1'b1, addr_mode_one, 32'h00000004);
    apb(1'b1, addr_mode_two, 32'h00000200);
    apb(1'b0, addr_mode_one, 32'h00000000);
    chk(q, 32'h00000004);
    apb(1'b0, 8'h14, 32'h00000000);
    chk({31'h0, perr_q}, 32'h00000001);
    $display("test regs done");
  endtask
  task automatic t_dyn(input int wl);
    for (int c = 0; c < 2; c++) begin
      run(1'b1, c[0]);
      chk(on_n, wl + 2);
      chk(ws_n, wl + 2);
      chk(ws_len, c ? 4 : 6);
      chk(on_len, c ? 4 : 6);
      chk({nom, wv}, 5'h05);
    end
    apb(1'b0, addr_latency, 32'h00000000);
    chk(q, wl);
    apb(1'b1, addr_control, 32'h00000001);
    run(1'b1, 1'b0);
    chk(ws_len, 4);
    apb(1'b1, addr_control, 32'h00000000);
    $display("test dynamic done");
  endtask
  task automatic t_other;
    run(1'b0, 1'b0);
    chk(ws_n, 0);
    chk(on_len, 4);
    apb(1'b1, addr_mode_two, 32'h00000000);
    run(1'b1, 1'b0);
    chk(ws_n, 0);
    chk(on_len, 6);
    apb(1'b1, addr_mode_one, 32'h00000000);
    run(1'b0, 1'b0);
    chk(on_n, 0);
    apb(1'b1, addr_mode_one, 32'h00000004);
    sr <= 1'b1;
    apb(1'b0, addr_mode_one, 32'h00000000);
    run(1'b0, 1'b0);
    chk(on_n, 0);
    sr <= 1'b0;
    $display("test other done");
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_dyn(5);
    apb(1'b1, addr_mode_two, 32'h00000208);
    t_dyn(6);
    t_other;
    stop_test;
  end
endmodule // testbench
